//--- hw/mms_cfg.svh
// constants for the measurement mode sequencer: offsets, fields, opcodes, timing
`ifndef MMS_CFG_SVH
`define MMS_CFG_SVH
`define REG_IFCFG 6'h02
`define REG_SCFG_A 6'h12
`define REG_THR_A 6'h13
`define REG_THR_B 6'h14
`define REG_THR_C 6'h15
`define REG_SCFG_B 6'h16
`define WR_OFFSET 8'h40
`define RD_TOP 8'h3F
`define WR_TOP 8'h79
`define OP_ENTER_NORMAL_OPERATION_CMD 8'hA8
`define OP_ENTER_COMMAND_MODE_CMD 8'hA9
`define OP_MEASURE 8'hAA
`define OP_CYCLIC 8'hAB
`define INT_MSB 8
`define INT_LSB 7
`define SSPOL_BIT 9
`define CYC_MSB 14
`define CYC_LSB 12
`define RES_MSB 3
`define RES_LSB 0
`define INT_EOC 2'h0
`define INT_ABOVE 2'h1
`define INT_BELOW 2'h2
`define INT_WINDOW 2'h3
`define RES_BASE 5'h0C
`define RES_MAX 5'h18
`define THR_W 5'h18
`define IFCFG_RST 16'h0000
`define SCFG_RST 16'h0004
`define THR_RST 16'h0000
`define CLK_MHZ 100
`define T_STA1_NS 1000
`define T_STA2_NS 2000
`define T_WUP1_NS 500
`define T_WUP2_NS 800
`define T_CFG_NS 300
`define T_CYC_UNIT_NS 100000
`define CYC_OF(ns) (((ns) * `CLK_MHZ + 999) / 1000)
`endif

//--- hw/mms_pkg.sv
// types shared by the measurement mode sequencer
package mms_pkg;
	typedef enum logic [1:0] {IFM_NONE, IFM_I2C, IFM_SPI} if_mode_t;
	typedef enum logic [1:0] {MUX_ANALOG_GROUND_REF, MUX_INPUTS, MUX_TEMP} mux_t;
	typedef struct packed {
		logic temp_cfg;
		mux_t mux;
		logic [4:0] res;
	} afe_ctrl_t;
	typedef struct packed {
		logic i2c;
		logic [7:0] op;
		logic [15:0] data;
	} cmd_word_t;
endpackage

//--- hw/measurement_mode_sequencer.sv
// power-up, interface choice, mode and measurement phase sequencer with eoc logic
`timescale 1ns/1ps
`include "mms_cfg.svh"

module measurement_mode_sequencer #(
	parameter int CYC_UNIT_CYC = `CYC_OF(`T_CYC_UNIT_NS)
) (
	input wire logic I_MCLK,
	input wire logic I_NRST,
	input wire logic I_LCLK,
	input wire logic I_CMD_VALID,
	input wire mms_pkg::cmd_word_t I_CMD,
	input wire logic I_SS,
	input wire logic I_EXT_RESET_PIN,
	input wire logic I_CONV_DONE,
	input wire logic I_CORR_DONE,
	input wire logic [23:0] I_CORR_SENSOR,
	output mms_pkg::afe_ctrl_t O_AFE,
	output logic O_CONV_START,
	output logic O_CORR_START,
	output logic O_CORE_PWR,
	output logic O_EOC,
	output logic O_BUSY,
	output logic O_CMD_MODE,
	output logic O_CYCLIC,
	output mms_pkg::if_mode_t O_IF_MODE,
	output logic [15:0] O_RD_DATA,
	output logic O_RD_VALID
);
	localparam logic [15:0] STA1_CYC = 16'(`CYC_OF(`T_STA1_NS));
	localparam logic [15:0] STA2_CYC = 16'(`CYC_OF(`T_STA2_NS));
	localparam logic [15:0] WUP1_CYC = 16'(`CYC_OF(`T_WUP1_NS));
	localparam logic [15:0] WUP2_CYC = 16'(`CYC_OF(`T_WUP2_NS));
	localparam logic [15:0] CFG_CYC = 16'(`CYC_OF(`T_CFG_NS));

	typedef enum logic [3:0] {
		ST_LOAD, ST_SLEEP, ST_WAKE, ST_ACTIVE, ST_SENSOR_ZERO_OFFSET_PHASE, ST_SM, ST_TEMPERATURE_ZERO_OFFSET_PHASE, ST_TM, ST_CORR, ST_PAUSE
	} state_t;

	// link side: hold the command word and flip a toggle; the clock may stop after it
	mms_pkg::cmd_word_t lhold_r;
	logic ltog_r;
	always_ff @(posedge I_LCLK or negedge I_NRST) begin
		if (!I_NRST) begin
			lhold_r <= '0;
			ltog_r <= 1'b0;
		end else if (I_CMD_VALID) begin
			lhold_r <= I_CMD;
			ltog_r <= ~ltog_r;
		end
	end

	// two-stage synchronisers for the toggle and the two pins; third stage only for edges
	logic tg_s1_r, tg_s2_r, tg_s3_r, ss_s1_r, ss_s2_r, rp_s1_r, rp_s2_r, rp_s3_r;
	always_ff @(posedge I_MCLK or negedge I_NRST) begin
		if (!I_NRST) begin
			{tg_s1_r, tg_s2_r, tg_s3_r} <= 3'h0;
			{ss_s1_r, ss_s2_r} <= 2'h0;
			{rp_s1_r, rp_s2_r, rp_s3_r} <= 3'h7;
		end else begin
			{tg_s1_r, tg_s2_r, tg_s3_r} <= {ltog_r, tg_s1_r, tg_s2_r};
			{ss_s1_r, ss_s2_r} <= {I_SS, ss_s1_r};
			{rp_s1_r, rp_s2_r, rp_s3_r} <= {I_EXT_RESET_PIN, rp_s1_r, rp_s2_r};
		end
	end

	state_t state_r, state_nxt;
	logic [15:0] pwr_cnt_r, wk_cnt_r;
	logic [23:0] cyc_cnt_r;
	logic [15:0] ifcfg_r, scfg_a_r, thr_a_r, thr_b_r, thr_c_r, scfg_b_r;
	mms_pkg::if_mode_t mode_r, mode_nxt;
	logic cmd_mode_r, cyclic_r, first_done_r, meas_req_r, eoc_nxt;
	mms_pkg::afe_ctrl_t afe_nxt;

	wire rst_fall = rp_s3_r & ~rp_s2_r;
	wire cmd_new = tg_s2_r ^ tg_s3_r;
	wire mms_pkg::cmd_word_t cmd = lhold_r;
	wire sta1_ok = pwr_cnt_r >= STA1_CYC;
	wire sta2_ok = pwr_cnt_r >= STA2_CYC;
	wire ss_act = ss_s2_r == ifcfg_r[`SSPOL_BIT];
	wire [1:0] int_setup = ifcfg_r[`INT_MSB:`INT_LSB];
	wire [2:0] cyc_code = ifcfg_r[`CYC_MSB:`CYC_LSB];

	// protocol check: i2c once locked to i2c, or before any lock while slave select idle; spi only once locked
	wire proto_ok = (cmd.i2c && mode_r == mms_pkg::IFM_I2C) ||
		(cmd.i2c && mode_r == mms_pkg::IFM_NONE && !ss_act) ||
		(!cmd.i2c && mode_r == mms_pkg::IFM_SPI);
	wire wake_ok = state_r == ST_WAKE && wk_cnt_r >= WUP1_CYC;
	wire idle_st = state_r == ST_SLEEP || state_r == ST_ACTIVE || state_r == ST_PAUSE;
	wire cmd_acc = cmd_new && sta1_ok && proto_ok && (idle_st || wake_ok);
	wire is_wr = cmd.op >= `WR_OFFSET && cmd.op <= `WR_TOP;
	wire is_rd = cmd.op <= `RD_TOP;
	wire [5:0] wr_adr = 6'(cmd.op - `WR_OFFSET);
	wire is_cm = cmd.op == `OP_ENTER_COMMAND_MODE_CMD;
	wire is_nom = cmd.op == `OP_ENTER_NORMAL_OPERATION_CMD;
	wire is_meas = cmd.op == `OP_MEASURE || cmd.op == `OP_CYCLIC;
	wire go_cm = cmd_acc && is_cm && !first_done_r;
	wire go_nom = cmd_acc && is_nom && cmd_mode_r;
	// command mode starts phases straight from active, so the second delay gates here
	wire go_meas = cmd_acc && is_meas && state_r != ST_WAKE &&
		(state_r != ST_ACTIVE || sta2_ok);

	// resolution from the sensor config, clamped to the threshold width
	wire [4:0] res_raw = `RES_BASE + 5'(scfg_a_r[`RES_MSB:`RES_LSB]);
	wire [4:0] res = (res_raw > `RES_MAX) ? `RES_MAX : res_raw;
	wire [23:0] thr1 = {thr_a_r, thr_b_r[15:8]};
	wire [23:0] thr2 = {thr_b_r[7:0], thr_c_r};
	// low bits below the resolution are dropped
	wire [23:0] cmp_mask = 24'hFFFFFF << (`THR_W - res);
	wire [23:0] c_m = I_CORR_SENSOR & cmp_mask;
	wire [23:0] t1_m = thr1 & cmp_mask;
	wire [23:0] t2_m = thr2 & cmp_mask;
	// eoc meaning from the setup field
	wire int_hit = (int_setup == `INT_ABOVE) ? (c_m > t1_m) :
		(int_setup == `INT_BELOW) ? (c_m < t1_m) :
		(int_setup == `INT_WINDOW) ? (c_m < t1_m || c_m > t2_m) : 1'b1;
	wire corr_end = state_r == ST_CORR && I_CORR_DONE;
	wire phase_st = state_r == ST_SENSOR_ZERO_OFFSET_PHASE || state_r == ST_SM || state_r == ST_TEMPERATURE_ZERO_OFFSET_PHASE ||
		state_r == ST_TM;
	wire cyc_end = cyc_cnt_r >= 24'(CYC_UNIT_CYC) * 24'({21'h0, cyc_code} + 24'h1);
	wire rd_hit = cmd_acc && is_rd;
	wire [5:0] rd_adr = cmd.op[5:0];
	wire [15:0] rd_val = (rd_adr == `REG_IFCFG) ? ifcfg_r : (rd_adr == `REG_SCFG_A) ? scfg_a_r :
		(rd_adr == `REG_THR_A) ? thr_a_r : (rd_adr == `REG_THR_B) ? thr_b_r :
		(rd_adr == `REG_THR_C) ? thr_c_r : (rd_adr == `REG_SCFG_B) ? scfg_b_r : 16'h0000;

	// next state: sleep or stay active after a run, loop when cyclic
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_LOAD: if (wk_cnt_r >= CFG_CYC) state_nxt = ST_SLEEP;
			ST_SLEEP: if (go_cm || go_meas) state_nxt = ST_WAKE;
			ST_WAKE: begin
				if (meas_req_r && wk_cnt_r >= WUP2_CYC && sta2_ok) state_nxt = ST_SENSOR_ZERO_OFFSET_PHASE;
				else if (!meas_req_r && wk_cnt_r >= WUP1_CYC) state_nxt = ST_ACTIVE;
			end
			ST_ACTIVE: begin
				if (go_meas) state_nxt = ST_SENSOR_ZERO_OFFSET_PHASE;
				else if (go_nom) state_nxt = ST_SLEEP;
			end
			ST_SENSOR_ZERO_OFFSET_PHASE: if (I_CONV_DONE) state_nxt = ST_SM;
			ST_SM: if (I_CONV_DONE) state_nxt = ST_TEMPERATURE_ZERO_OFFSET_PHASE;
			ST_TEMPERATURE_ZERO_OFFSET_PHASE: if (I_CONV_DONE) state_nxt = ST_TM;
			ST_TM: if (I_CONV_DONE) state_nxt = ST_CORR;
			// back to sleep, to active in command mode, or pause when cyclic
			ST_CORR: begin
				if (I_CORR_DONE) begin
					if (cyclic_r) state_nxt = ST_PAUSE;
					else if (cmd_mode_r) state_nxt = ST_ACTIVE;
					else state_nxt = ST_SLEEP;
				end
			end
			ST_PAUSE: begin
				if (go_meas) state_nxt = ST_WAKE;
				else if (cyc_end && cmd_mode_r) state_nxt = ST_SENSOR_ZERO_OFFSET_PHASE;
				else if (cyc_end) state_nxt = ST_WAKE;
			end
			default: state_nxt = ST_LOAD;
		endcase
		if (rst_fall) state_nxt = ST_LOAD;
	end

	// analogue set-up per phase; registered so it lines up with the state
	always_comb begin
		afe_nxt.res = res;
		afe_nxt.temp_cfg = 1'b0;
		afe_nxt.mux = mms_pkg::MUX_ANALOG_GROUND_REF;
		case (state_nxt)
			ST_SENSOR_ZERO_OFFSET_PHASE: afe_nxt.mux = mms_pkg::MUX_ANALOG_GROUND_REF;
			ST_SM: afe_nxt.mux = mms_pkg::MUX_INPUTS;
			ST_TEMPERATURE_ZERO_OFFSET_PHASE: afe_nxt.temp_cfg = 1'b1;
			ST_TM: begin
				afe_nxt.temp_cfg = 1'b1;
				afe_nxt.mux = mms_pkg::MUX_TEMP;
			end
			default: afe_nxt.mux = mms_pkg::MUX_ANALOG_GROUND_REF;
		endcase
	end

	// eoc: low at each start except in a cyclic run with a threshold setup, set from the compare when correction ends
	always_comb begin
		eoc_nxt = O_EOC;
		if (state_nxt == ST_SENSOR_ZERO_OFFSET_PHASE && state_r != ST_SENSOR_ZERO_OFFSET_PHASE && !(cyclic_r && int_setup != `INT_EOC))
			eoc_nxt = 1'b0;
		if (corr_end) eoc_nxt = int_hit;
		if (rst_fall) eoc_nxt = 1'b0;
	end

	// interface lock: only a full power-on reset clears it
	always_comb begin
		mode_nxt = mode_r;
		if (mode_r == mms_pkg::IFM_NONE && cmd_acc && cmd.i2c) mode_nxt = mms_pkg::IFM_I2C;
		else if (mode_r == mms_pkg::IFM_NONE && sta1_ok && ss_act) mode_nxt = mms_pkg::IFM_SPI;
	end

	// sequencer state and counters
	always_ff @(posedge I_MCLK or negedge I_NRST) begin
		if (!I_NRST) begin
			state_r <= ST_LOAD;
			pwr_cnt_r <= 16'h0000;
			wk_cnt_r <= 16'h0000;
			cyc_cnt_r <= 24'h000000;
			mode_r <= mms_pkg::IFM_NONE;
		end else begin
			state_r <= state_nxt;
			// power-up timer restarts on the pin
			pwr_cnt_r <= rst_fall ? 16'h0000 : (sta2_ok ? pwr_cnt_r : pwr_cnt_r + 16'h0001);
			wk_cnt_r <= (state_nxt != state_r) ? 16'h0000 : wk_cnt_r + 16'(wk_cnt_r != 16'hFFFF);
			cyc_cnt_r <= (state_r == ST_PAUSE) ? cyc_cnt_r + 24'h000001 : 24'h000000;
			mode_r <= mode_nxt;
		end
	end

	// mode flags; a measure while paused turns cyclic into a fresh request
	always_ff @(posedge I_MCLK or negedge I_NRST) begin
		if (!I_NRST) begin
			cmd_mode_r <= 1'b0;
			cyclic_r <= 1'b0;
			first_done_r <= 1'b0;
			meas_req_r <= 1'b0;
		end else if (rst_fall) begin
			cmd_mode_r <= 1'b0;
			cyclic_r <= 1'b0;
			first_done_r <= 1'b0;
			meas_req_r <= 1'b0;
		end else begin
			first_done_r <= first_done_r | cmd_acc;
			cmd_mode_r <= go_cm | (cmd_mode_r & ~go_nom);
			if (go_meas) cyclic_r <= cmd.op == `OP_CYCLIC;
			else if (go_nom) cyclic_r <= 1'b0;
			if (go_meas || (state_r == ST_PAUSE && cyc_end)) meas_req_r <= 1'b1;
			else if (go_cm) meas_req_r <= 1'b0;
		end
	end

	// register file written by commands at opcode plus the write offset
	always_ff @(posedge I_MCLK or negedge I_NRST) begin
		if (!I_NRST) begin
			{ifcfg_r, scfg_a_r, scfg_b_r} <= {`IFCFG_RST, `SCFG_RST, `SCFG_RST};
			{thr_a_r, thr_b_r, thr_c_r} <= {`THR_RST, `THR_RST, `THR_RST};
		end else if (cmd_acc && is_wr) begin
			if (wr_adr == `REG_IFCFG) ifcfg_r <= cmd.data;
			if (wr_adr == `REG_SCFG_A) scfg_a_r <= cmd.data;
			if (wr_adr == `REG_THR_A) thr_a_r <= cmd.data;
			if (wr_adr == `REG_THR_B) thr_b_r <= cmd.data;
			if (wr_adr == `REG_THR_C) thr_c_r <= cmd.data;
			if (wr_adr == `REG_SCFG_B) scfg_b_r <= cmd.data;
		end
	end

	// registered outputs
	always_ff @(posedge I_MCLK or negedge I_NRST) begin
		if (!I_NRST) begin
			O_AFE <= '0;
			{O_CONV_START, O_CORR_START, O_EOC, O_BUSY, O_RD_VALID} <= 5'h00;
			{O_CORE_PWR, O_CMD_MODE, O_CYCLIC} <= 3'h4;
			O_IF_MODE <= mms_pkg::IFM_NONE;
			O_RD_DATA <= 16'h0000;
		end else begin
			O_AFE <= afe_nxt;
			O_CONV_START <= state_nxt != state_r && state_nxt inside {ST_SENSOR_ZERO_OFFSET_PHASE, ST_SM, ST_TEMPERATURE_ZERO_OFFSET_PHASE, ST_TM};
			O_CORR_START <= state_nxt == ST_CORR && state_r != ST_CORR;
			O_EOC <= eoc_nxt;
			O_BUSY <= state_nxt inside {ST_SENSOR_ZERO_OFFSET_PHASE, ST_SM, ST_TEMPERATURE_ZERO_OFFSET_PHASE, ST_TM, ST_CORR};
			O_CORE_PWR <= !(state_nxt inside {ST_SLEEP, ST_PAUSE});
			O_CMD_MODE <= cmd_mode_r;
			O_CYCLIC <= cyclic_r;
			O_IF_MODE <= mode_nxt;
			O_RD_VALID <= rd_hit;
			if (rd_hit) O_RD_DATA <= rd_val;
		end
	end

	default clocking cb @(posedge I_MCLK); endclocking
	default disable iff (!I_NRST);

	start_gate_a: assert property (O_RD_VALID |-> $past(pwr_cnt_r) >= STA1_CYC)
		else $error("command taken before start-up delay");
	meas_gate_a: assert property ($rose(state_r == ST_SENSOR_ZERO_OFFSET_PHASE) |-> sta2_ok)
		else $error("measurement before second start-up delay");
	pin_reset_a: assert property (rst_fall |=> state_r == ST_LOAD && pwr_cnt_r == 16'h0000)
		else $error("reset pin did not restart power-up");
	wake_cmd_a: assert property (cmd_acc && $past(state_r) == ST_WAKE && state_r == ST_WAKE
		|-> wk_cnt_r >= WUP1_CYC)
		else $error("command taken inside wake delay");
	wake_meas_a: assert property (state_r == ST_WAKE ##1 state_r == ST_SENSOR_ZERO_OFFSET_PHASE
		|-> $past(wk_cnt_r) >= WUP2_CYC)
		else $error("conversion started inside wake delay");
	zero_mux_a: assert property (state_r inside {ST_SENSOR_ZERO_OFFSET_PHASE, ST_TEMPERATURE_ZERO_OFFSET_PHASE}
		|-> O_AFE.mux == mms_pkg::MUX_ANALOG_GROUND_REF && O_AFE.temp_cfg == (state_r == ST_TEMPERATURE_ZERO_OFFSET_PHASE))
		else $error("zero phase set-up wrong");
	sens_mux_a: assert property (state_r == ST_SM
		|-> O_AFE.mux == mms_pkg::MUX_INPUTS && !O_AFE.temp_cfg)
		else $error("sensor phase set-up wrong");
	tzero_cfg_a: assert property (state_r == ST_TEMPERATURE_ZERO_OFFSET_PHASE |-> O_AFE.temp_cfg)
		else $error("temperature zero phase set-up wrong");
	temp_mux_a: assert property (state_r == ST_TM
		|-> O_AFE.mux == mms_pkg::MUX_TEMP && O_AFE.temp_cfg)
		else $error("temperature phase set-up wrong");
	phase_order_a: assert property ($rose(state_r == ST_CORR) |-> $past(state_r) == ST_TM)
		else $error("correction not after temperature phase");
	res_mask_a: assert property (O_CONV_START |-> O_AFE.res <= `RES_MAX && O_AFE.res >= `RES_BASE)
		else $error("resolution out of range");
	plain_eoc_a: assert property (int_setup == `INT_EOC && $rose(O_EOC)
		|-> $past(state_r) == ST_CORR)
		else $error("plain eoc rose outside correction end");
	single_eoc_a: assert property (!cyclic_r && $rose(state_r == ST_SENSOR_ZERO_OFFSET_PHASE) |-> !O_EOC)
		else $error("eoc not low at start");
	i2c_lock_a: assert property (O_IF_MODE == mms_pkg::IFM_I2C |=> O_IF_MODE == mms_pkg::IFM_I2C)
		else $error("i2c lock lost");
	cm_first_a: assert property ($rose(cmd_mode_r) |-> !$past(first_done_r))
		else $error("command mode entered late");
	busy_flag_a: assert property (phase_st || state_r == ST_CORR |-> O_BUSY)
		else $error("busy not shown");
	load_pwr_a: assert property (state_r == ST_LOAD |-> O_CORE_PWR)
		else $error("core not powered during config load");
	norm_sleep_a: assert property (corr_end && !cyclic_r && !cmd_mode_r && !rst_fall
		|=> !O_CORE_PWR && !O_BUSY)
		else $error("normal mode did not return to sleep");
	cmd_stay_a: assert property (state_r == ST_ACTIVE && !go_nom && !rst_fall |=> O_CORE_PWR)
		else $error("command mode left active state");
	cyc_hold_a: assert property ($rose(state_r == ST_SENSOR_ZERO_OFFSET_PHASE) && $past(cyclic_r) &&
		$past(int_setup) != `INT_EOC |-> O_EOC == $past(O_EOC))
		else $error("cyclic interrupt level dropped at start");
	cmd_meas_c: cover property (state_r == ST_ACTIVE ##1 state_r == ST_SENSOR_ZERO_OFFSET_PHASE);
	cyclic_run_c: cover property (state_r == ST_PAUSE ##1 state_r == ST_WAKE);
	cmd_mode_c: cover property ($rose(O_CMD_MODE));
	spi_lock_c: cover property (O_IF_MODE == mms_pkg::IFM_SPI);
	window_hit_c: cover property (corr_end && int_setup == `INT_WINDOW && int_hit);
endmodule

//--- dv/host_model.sv
// host side of the link: frames one command at a time and drives slave select
`timescale 1ns/1ps
module host_model (
	output logic o_lclk,
	output logic o_valid,
	output mms_pkg::cmd_word_t o_cmd,
	output logic o_ss
);
	// link clock stands still between frames; select idles inactive
	initial begin
		o_lclk = 1'b0;
		o_valid = 1'b0;
		o_cmd = '0;
		o_ss = 1'b1;
	end
	// caller decides when the device may take a command
	// three idle cycles follow each word so two words never come too close
	task automatic send(input logic i2c, input logic [7:0] op, input logic [15:0] data);
		#3;
		o_cmd = {i2c, op, data};
		o_valid = 1'b1;
		#80 o_lclk = 1'b1;
		#80 o_lclk = 1'b0;
		o_valid = 1'b0;
		o_cmd = ~o_cmd; // no stale word left on the lines
		repeat (3) begin
			#80 o_lclk = 1'b1;
			#80 o_lclk = 1'b0;
		end
	endtask
	task automatic select(input logic lvl);
		o_ss <= lvl;
	endtask
endmodule

//--- dv/tb.sv
// self-checking bench: power-up, measurement sequence, eoc and port choice
`timescale 1ns/1ps
`include "mms_cfg.svh"
module tb;
	localparam int UNIT = 20;
	logic clk, nrst, rst_pin, conv_done, corr_done, keep, eoc_exp, lclk, cmd_valid, ss;
	logic conv_start, corr_start, core_pwr, eoc, busy, cmd_mode, cyclic, rd_valid;
	logic [1:0] setup;
	logic [4:0] res_exp;
	logic [15:0] rd_data;
	logic [23:0] corr_val, src;
	logic [31:0] seed;
	logic [2:0] phase_exp [4] = '{3'h0, 3'h1, 3'h4, 3'h6};
	logic [23:0] vals [4] = '{24'h100000, 24'h800000, 24'hF00000, 24'h400000};
	logic [15:0] rd_q [$];
	mms_pkg::cmd_word_t cmd;
	mms_pkg::afe_ctrl_t afe;
	mms_pkg::if_mode_t if_mode;
	int errors, checks, phase, corrs;

	measurement_mode_sequencer #(.CYC_UNIT_CYC(UNIT)) measurement_mode_sequencer_i (
		.I_MCLK(clk), .I_NRST(nrst), .I_LCLK(lclk), .I_CMD_VALID(cmd_valid), .I_CMD(cmd),
		.I_SS(ss), .I_EXT_RESET_PIN(rst_pin), .I_CONV_DONE(conv_done),
		.I_CORR_DONE(corr_done), .I_CORR_SENSOR(corr_val), .O_AFE(afe),
		.O_CONV_START(conv_start), .O_CORR_START(corr_start), .O_CORE_PWR(core_pwr),
		.O_EOC(eoc), .O_BUSY(busy), .O_CMD_MODE(cmd_mode), .O_CYCLIC(cyclic),
		.O_IF_MODE(if_mode), .O_RD_DATA(rd_data), .O_RD_VALID(rd_valid));
	host_model host_model_i (.o_lclk(lclk), .o_valid(cmd_valid), .o_cmd(cmd), .o_ss(ss));

	initial clk = 1'b0;
	always #5 clk = ~clk;

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	// expected pin level; thresholds sit far apart so any resolution up to 16 bits agrees
	function automatic logic lvl(input logic [1:0] s, input logic [23:0] v);
		case (s)
			2'h0: return 1'b1;
			2'h1: return v[23:8] > 16'h4000;
			2'h2: return v[23:8] < 16'h4000;
			default: return v[23:8] < 16'h4000 || v[23:8] > 16'hC000;
		endcase
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish;
		errors += rd_q.size(); // reads never answered
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		host_model_i.send(1'b1, `WR_OFFSET + {2'h0, a}, d);
	endtask
	task automatic rd(input logic i2c, input logic [5:0] a, input logic [15:0] e);
		rd_q.push_back(e);
		host_model_i.send(i2c, {2'h0, a}, 16'h0000);
	endtask
	// bounded wait for n more finished corrections
	task automatic waitc(input int n);
		int c0, k;
		c0 = corrs;
		k = 0;
		while (corrs < c0 + n && k < 3000) begin
			@(posedge clk);
			k++;
		end
		if (k == 3000) errors++;
		repeat (2) @(posedge clk);
	endtask
	task automatic meas(input logic [7:0] op);
		host_model_i.send(1'b1, op, 16'h0000);
		waitc(1);
	endtask

	// converter and correction stand-in with random latencies
	always @(posedge clk) begin
		if (conv_start) begin
			chk({afe.temp_cfg, afe.mux}, phase_exp[phase]);
			chk(busy, 1'b1);
			if (!afe.temp_cfg) chk(afe.res, res_exp);
			if (phase == 0) begin
				if (!keep) eoc_exp = 1'b0;
				chk(eoc, eoc_exp);
			end
			phase = (phase + 1) % 4;
			seed = xs(seed);
			repeat (4 + seed[3:0]) @(posedge clk);
			conv_done <= 1'b1;
			@(posedge clk);
			conv_done <= 1'b0;
		end
		if (corr_start) begin
			chk(phase, 0);
			seed = xs(seed);
			repeat (2 + seed[2:0]) @(posedge clk);
			corr_val <= {src[23:8], seed[15:8]}; // low byte is noise, below resolution at 16 bits; at 20 bits its top nibble is compared
			corr_done <= 1'b1;
			eoc_exp = lvl(setup, src);
			corrs++;
			@(posedge clk);
			corr_val <= ~corr_val;
			corr_done <= 1'b0;
		end
	end

	// read answers are matched against the oldest expectation
	always @(posedge clk) begin
		if (rd_valid && rd_q.size() == 0) chk(1'b1, 1'b0);
		else if (rd_valid) chk(rd_data, rd_q.pop_front());
	end

	initial begin
		#400000;
		errors++;
		tally_and_finish;
	end

	initial begin
		{nrst, conv_done, corr_done, keep, eoc_exp} = '0;
		{rst_pin, corr_val, src, setup} = {1'b1, 50'h0};
		seed = 32'h0000D541;
		res_exp = 5'h10;
		{errors, checks, phase, corrs} = '0;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		repeat (10) @(posedge clk);
		chk(core_pwr, 1'b1);
		host_model_i.send(1'b1, {2'h0, `REG_IFCFG}, 16'h0000);
		chk(core_pwr, 1'b0);
		repeat (30) @(posedge clk);
		rd(1'b1, `REG_SCFG_A, `SCFG_RST);
		chk(if_mode, mms_pkg::IFM_I2C);
		host_model_i.send(1'b0, {2'h0, `REG_IFCFG}, 16'h0000);
		host_model_i.send(1'b1, `OP_ENTER_COMMAND_MODE_CMD, 16'h0000);
		chk(cmd_mode, 1'b0);
		rd(1'b1, 6'h30, 16'h0000);
		wr(`REG_THR_A, 16'h4000);
		wr(`REG_THR_B, 16'h00C0);
		wr(`REG_THR_C, 16'h0000);
		rd(1'b1, `REG_THR_B, 16'h00C0);
		// every pin setup against results below, between and above the thresholds
		for (int s = 0; s < 4; s++) begin
			setup = s[1:0];
			wr(`REG_IFCFG, {7'h00, setup, 7'h00});
			// last value sits on the first threshold: only masked noise bits differ
			for (int v = 0; v < 4; v++) begin
				src = vals[v];
				meas(`OP_MEASURE);
				chk(eoc, eoc_exp);
				chk(busy, 1'b0);
				chk(core_pwr, 1'b0);
			end
		end
		// cyclic run: pin keeps the last result across the next start
		{setup, src, keep} = {2'h1, vals[2], 1'b1};
		wr(`REG_IFCFG, 16'h0080);
		meas(`OP_CYCLIC);
		chk(cyclic, 1'b1);
		repeat (5) @(posedge clk);
		chk(core_pwr, 1'b0);
		src = vals[0];
		waitc(1);
		chk(eoc, 1'b0);
		keep = 1'b0;
		src = vals[2];
		meas(`OP_MEASURE);
		chk(cyclic, 1'b0);
		// reset pin restarts power-up but keeps the port choice
		rst_pin <= 1'b0;
		repeat (2) @(posedge clk);
		rst_pin <= 1'b1;
		repeat (6) @(posedge clk);
		chk(core_pwr, 1'b1);
		chk(eoc, 1'b0);
		chk(if_mode, mms_pkg::IFM_I2C);
		eoc_exp = 1'b0;
		repeat (100) @(posedge clk);
		host_model_i.send(1'b1, `OP_ENTER_COMMAND_MODE_CMD, 16'h0000);
		repeat (60) @(posedge clk);
		chk(cmd_mode, 1'b1);
		wr(`REG_SCFG_A, 16'h0008);
		res_exp = 5'h14;
		meas(`OP_MEASURE);
		chk(core_pwr, 1'b1);
		chk(eoc, 1'b1);
		host_model_i.send(1'b1, `OP_ENTER_NORMAL_OPERATION_CMD, 16'h0000);
		chk(cmd_mode, 1'b0);
		// fresh power-up, then slave select first picks spi
		nrst <= 1'b0;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		repeat (110) @(posedge clk);
		host_model_i.select(1'b0);
		repeat (8) @(posedge clk);
		chk(if_mode, mms_pkg::IFM_SPI);
		host_model_i.send(1'b1, {2'h0, `REG_IFCFG}, 16'h0000);
		rd(1'b0, `REG_SCFG_A, `SCFG_RST);
		tally_and_finish;
	end
endmodule
